// File: core/sas_defs.vh
/*
 * Constants of the sync activity and source status block: register
 * indices, field positions, reset values and timing.
 * Assumes inclusion by bare name from the block's single design file.
 */
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH

// How it works
// (RULE1) Green-embedded sync activity sets status bit 6 of 0x15, else zero.
// (RULE2) Green-embedded detection may fire on plain video; logic tolerates it.
// (RULE3) Frame sync detect, bit 5 of 0x15, set only by toggling input.
// (RULE4) Digital clock detect, bit 4 of 0x15, follows activity on that clock.
// (RULE5) Analog detect ORs line, green and frame detects; digital is clock.
// (RULE6) No override: digital only gives 1, analog only 0, none seeks.
// (RULE7) Both detected, no override: interface flag equals priority bit.
// (RULE8) Override bit 2 of 0x0F forces interface flag to bit 1.
// (RULE9) Interface flag, bit 3 of 0x15: analog 0, digital 1.
// (RULE10) Line source: line only 0, green only 1, else bit 3 of 0x10.
// (RULE11) Line source override, bit 4 of 0x10, forces bit 3 value.
// (RULE12) Line source flag, bit 7 of 0x16: line pin 0, green 1.
// (RULE13) Line sync polarity in bit 6 of 0x16: low 0, high 1.
// (RULE14) Frame source follows frame detect, or bit 0 when bit 1 set.
// (RULE15) Frame source flag, bit 5 of 0x16: pin 0, separator 1.
// (RULE16) Frame sync output polarity, bit 4 of 0x16: high 0, low 1.
// (RULE17) Coast polarity in bit 3 of 0x16, meaningful for internal coast.
// (RULE18) Coast polarity reads 0 for active low, 1 for active high.
// (RULE19) Line sync detect, bit 7 of 0x15, set only by toggling input.
// (RULE20) Detectors flag toggles per window, clear after quiet window.

// ==========================================================
// Register indices; byte address is four times the index
`define SAS_IDX_IF_CTRL 6'h0f
`define SAS_IDX_SYNC_CTRL 6'h10
`define SAS_IDX_ACT_STAT 6'h15
`define SAS_IDX_SRC_STAT 6'h16
`define SAS_CTRL_RESET 8'h00

// ==========================================================
// Control fields
`define SAS_IF_PRIO_BIT 1
`define SAS_IF_OVR_BIT 2
`define SAS_LSRC_SEL_BIT 3
`define SAS_LSRC_OVR_BIT 4
`define SAS_FSRC_SEL_BIT 0
`define SAS_FSRC_OVR_BIT 1

// ==========================================================
// Activity status fields (0x15)
`define SAS_LINE_DET_BIT 7
`define SAS_GREEN_DET_BIT 6
`define SAS_FRAME_DET_BIT 5
`define SAS_DCLK_DET_BIT 4
`define SAS_AI_BIT 3

// ==========================================================
// Source and polarity status fields (0x16)
`define SAS_LSRC_BIT 7
`define SAS_LPOL_BIT 6
`define SAS_FSRC_BIT 5
`define SAS_FPOL_BIT 4
`define SAS_CPOL_BIT 3

// ==========================================================
// Input channel numbering
`define SAS_CH_LINE 0
`define SAS_CH_GREEN 1
`define SAS_CH_FRAME 2
`define SAS_CH_DCLK 3
`define SAS_CH_SEP 4
`define SAS_CH_COAST 5
`define SAS_NCH 6
`define SAS_NDET 4
`define SAS_NPOL 3

// ==========================================================
// Timing
`define SAS_CLK_MHZ 10
`define SAS_WINDOW_US 40000
`define SAS_CNT_W 20
`define SAS_ARM_W 2
`define SAS_ARM_LAST 2'h3

`endif

// File: core/sas_status.v
/*
 * Sync activity detection, interface and sync source selection and
 * polarity reporting, with a classic Wishbone register slave.
 * Assumes sync, coast and digital clock inputs are asynchronous pins;
 * the digital clock must toggle slowly enough to be seen at 10 MHz
 * (feed a divided copy of the fast link clock).
 * Assumes every sync period is shorter than the observation window,
 * and that the bus master holds each request until it sees ack.
 * Edges are ignored until the synchronisers have filled after reset.
 */
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
`include "sas_defs.vh"

module sas_status #(
    parameter WINDOW_CYCLES = `SAS_WINDOW_US * `SAS_CLK_MHZ
)
(
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire line_sync_i,
    input wire green_embedded_sync_i,
    input wire frame_sync_i,
    input wire dclk_i,
    input wire sep_frame_sync_i,
    input wire coast_i,
    output reg active_interface_flag_o,
    output reg selected_line_sync_source_o,
    output reg selected_frame_sync_source_o,
    output reg soft_power_down_o
);

    localparam [31:0] WIN_LAST_W = WINDOW_CYCLES - 1;
    localparam [31:0] WIN_HALF_W = WINDOW_CYCLES / 2;
    localparam [`SAS_CNT_W-1:0] WIN_LAST = WIN_LAST_W[`SAS_CNT_W-1:0];
    localparam [`SAS_CNT_W-1:0] WIN_HALF = WIN_HALF_W[`SAS_CNT_W-1:0];

    // ==========================================================
    // Helpers
    function reg_hit;
        input [7:0] adr;
        input [5:0] idx;
        begin
            reg_hit = (adr[7:2] == idx) && (adr[1:0] == 2'b00);
        end
    endfunction

    function pick;
        input ovr;
        input user;
        input auto;
        begin
            pick = ovr ? user : auto;
        end
    endfunction

    // ==========================================================
    // Priming: the edge flop holds a real sample only once the
    // chain has filled, so a pin idling high gives no false edge
    reg [`SAS_ARM_W-1:0] arm_q;
    wire armed;

    assign armed = (arm_q == `SAS_ARM_LAST);

    always @(posedge clk_i)
    begin
        if (rst_i)
            arm_q <= {`SAS_ARM_W{1'b0}};
        else if (!armed)
            arm_q <= arm_q + 1'b1;
    end

    // ==========================================================
    // Input synchronisers and edge detection
    wire [`SAS_NCH-1:0] pin_raw;
    wire [`SAS_NCH-1:0] pin_s;
    wire [`SAS_NCH-1:0] pin_edge;

    assign pin_raw[`SAS_CH_LINE] = line_sync_i;
    assign pin_raw[`SAS_CH_GREEN] = green_embedded_sync_i;
    assign pin_raw[`SAS_CH_FRAME] = frame_sync_i;
    assign pin_raw[`SAS_CH_DCLK] = dclk_i;
    assign pin_raw[`SAS_CH_SEP] = sep_frame_sync_i;
    assign pin_raw[`SAS_CH_COAST] = coast_i;

    genvar g;
    generate
        for (g = 0; g < `SAS_NCH; g = g + 1)
        begin : g_sync
            reg meta_q;
            reg sync_q;
            reg last_q;
            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    last_q <= 1'b0;
                end
                else
                begin
                    meta_q <= pin_raw[g];
                    sync_q <= meta_q;
                    last_q <= sync_q;
                end
            end
            assign pin_s[g] = sync_q;
            assign pin_edge[g] = (sync_q ^ last_q) & armed;
        end
    endgenerate

    // ==========================================================
    // Observation window
    reg [`SAS_CNT_W-1:0] win_q;
    wire win_end;

    assign win_end = (win_q == WIN_LAST);

    always @(posedge clk_i)
    begin
        if (rst_i)
            win_q <= {`SAS_CNT_W{1'b0}};
        else if (win_end)
            win_q <= {`SAS_CNT_W{1'b0}};
        else
            win_q <= win_q + 1'b1;
    end

    // ==========================================================
    // Activity detectors: a held level never sets the flag
    wire [`SAS_NDET-1:0] det;

    generate
        for (g = 0; g < `SAS_NDET; g = g + 1)
        begin : g_act
            reg seen_q;
            reg det_q;
            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    seen_q <= 1'b0;
                    det_q <= 1'b0;
                end
                else if (win_end)
                begin
                    det_q <= seen_q | pin_edge[g]; // RULE20
                    seen_q <= 1'b0;
                end
                else if (pin_edge[g])
                    seen_q <= 1'b1;
            end
            assign det[g] = det_q;
        end
    endgenerate

    wire line_det;
    wire green_det;
    wire frame_det;
    wire dclk_det;

    assign line_det = det[`SAS_CH_LINE]; // RULE19
    assign green_det = det[`SAS_CH_GREEN]; // RULE1
    assign frame_det = det[`SAS_CH_FRAME]; // RULE3
    assign dclk_det = det[`SAS_CH_DCLK]; // RULE4

    // ==========================================================
    // Control registers
    reg [7:0] if_ctrl_q;
    reg [7:0] sync_ctrl_q;
    wire wr_ok;

    assign wr_ok = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            if_ctrl_q <= `SAS_CTRL_RESET;
            sync_ctrl_q <= `SAS_CTRL_RESET;
        end
        else if (wr_ok)
        begin
            if (reg_hit(wb_adr_i, `SAS_IDX_IF_CTRL))
                if_ctrl_q <= wb_dat_i[7:0];
            if (reg_hit(wb_adr_i, `SAS_IDX_SYNC_CTRL))
                sync_ctrl_q <= wb_dat_i[7:0];
        end
    end

    wire if_prio;
    wire if_ovr;
    wire lsrc_sel;
    wire lsrc_ovr;
    wire fsrc_sel;
    wire fsrc_ovr;

    assign if_prio = if_ctrl_q[`SAS_IF_PRIO_BIT];
    assign if_ovr = if_ctrl_q[`SAS_IF_OVR_BIT];
    assign lsrc_sel = sync_ctrl_q[`SAS_LSRC_SEL_BIT];
    assign lsrc_ovr = sync_ctrl_q[`SAS_LSRC_OVR_BIT];
    assign fsrc_sel = sync_ctrl_q[`SAS_FSRC_SEL_BIT];
    assign fsrc_ovr = sync_ctrl_q[`SAS_FSRC_OVR_BIT];

    // ==========================================================
    // Interface and source selection
    wire analog_det;
    reg ai_auto;
    reg lsrc_auto;

    // Green detection may be video; it widens analog detection and picks the line source only while line is quiet
    assign analog_det = line_det | green_det | frame_det; // RULE5 RULE2

    always @*
    begin
        case ({analog_det, dclk_det})
            2'b01: ai_auto = 1'b1; // RULE6
            2'b10: ai_auto = 1'b0; // RULE6
            2'b11: ai_auto = if_prio; // RULE7
            default: ai_auto = active_interface_flag_o;
        endcase
    end

    always @*
    begin
        case ({line_det, green_det})
            2'b10: lsrc_auto = 1'b0; // RULE10
            2'b01: lsrc_auto = 1'b1; // RULE10
            default: lsrc_auto = lsrc_sel; // RULE10
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            active_interface_flag_o <= 1'b0;
            selected_line_sync_source_o <= 1'b0;
            selected_frame_sync_source_o <= 1'b0;
            soft_power_down_o <= 1'b0;
        end
        else
        begin
            active_interface_flag_o <= pick(if_ovr, if_prio, ai_auto); // RULE8
            selected_line_sync_source_o <= pick(lsrc_ovr, lsrc_sel,
                lsrc_auto); // RULE11
            selected_frame_sync_source_o <= pick(fsrc_ovr, fsrc_sel,
                frame_det); // RULE14
            soft_power_down_o <= ~if_ovr & ~analog_det & ~dclk_det; // RULE6
        end
    end

    // ==========================================================
    // Polarity detectors: the level held for the shorter time is
    // taken as the pulse, so active high means mostly low
    wire [2:0] pol_src;
    wire [2:0] pol_hi;

    assign pol_src[0] = pin_s[`SAS_CH_LINE];
    assign pol_src[1] = selected_frame_sync_source_o ?
        pin_s[`SAS_CH_SEP] : pin_s[`SAS_CH_FRAME];
    assign pol_src[2] = pin_s[`SAS_CH_COAST];

    generate
        for (g = 0; g < `SAS_NPOL; g = g + 1)
        begin : g_pol
            reg [`SAS_CNT_W-1:0] high_q;
            reg pol_q;
            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    high_q <= {`SAS_CNT_W{1'b0}};
                    pol_q <= 1'b0;
                end
                else if (win_end)
                begin
                    pol_q <= (high_q < WIN_HALF);
                    high_q <= {`SAS_CNT_W{1'b0}};
                end
                else if (pol_src[g])
                    high_q <= high_q + 1'b1;
            end
            assign pol_hi[g] = pol_q;
        end
    endgenerate

    // ==========================================================
    // Status words
    reg [7:0] act_stat;
    reg [7:0] src_stat;

    always @*
    begin
        act_stat = 8'h00;
        act_stat[`SAS_LINE_DET_BIT] = line_det; // RULE19
        act_stat[`SAS_GREEN_DET_BIT] = green_det; // RULE1
        act_stat[`SAS_FRAME_DET_BIT] = frame_det; // RULE3
        act_stat[`SAS_DCLK_DET_BIT] = dclk_det; // RULE4
        act_stat[`SAS_AI_BIT] = active_interface_flag_o; // RULE9
        src_stat = 8'h00;
        src_stat[`SAS_LSRC_BIT] = selected_line_sync_source_o; // RULE12
        src_stat[`SAS_LPOL_BIT] = pol_hi[0]; // RULE13
        src_stat[`SAS_FSRC_BIT] = selected_frame_sync_source_o; // RULE15
        src_stat[`SAS_FPOL_BIT] = ~pol_hi[1]; // RULE16
        // Only meaningful while the internal coast drives the pin
        src_stat[`SAS_CPOL_BIT] = pol_hi[2]; // RULE17 RULE18
    end

    // ==========================================================
    // Wishbone slave: ack one cycle after request, data with ack
    reg [7:0] rd_byte;
    wire wb_req;

    // A request counts once: ack low marks it as not yet answered
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always @*
    begin
        rd_byte = 8'h00;
        if (reg_hit(wb_adr_i, `SAS_IDX_IF_CTRL))
            rd_byte = if_ctrl_q;
        else if (reg_hit(wb_adr_i, `SAS_IDX_SYNC_CTRL))
            rd_byte = sync_ctrl_q;
        else if (reg_hit(wb_adr_i, `SAS_IDX_ACT_STAT))
            rd_byte = act_stat;
        else if (reg_hit(wb_adr_i, `SAS_IDX_SRC_STAT))
            rd_byte = src_stat;
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_req)
                wb_dat_o <= {24'h000000, rd_byte};
        end
    end

endmodule

// File: tb/sas_status_checker.sv
/* Port-level assertions for sas_status.
   Assumes a classic Wishbone master; bound to sas_status below. */
`timescale 1ns/1ns
module sas_status_checker #(
    parameter WINDOW_CYCLES = 64
)
(
    input logic clk_i,
    input logic rst_i,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [7:0] wb_adr_i,
    input logic [31:0] wb_dat_o,
    input logic wb_ack_o,
    input logic active_interface_flag_o,
    input logic selected_line_sync_source_o,
    input logic selected_frame_sync_source_o,
    input logic soft_power_down_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ==========================================
    // Bus handshake
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack missing");
    chk_ack_pulse: assert property (wb_ack_o |-> ##1 !wb_ack_o)
        else $error("ack too long");
    chk_ack_cause: assert property (wb_ack_o
        |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o)) else $error("stray ack");
    chk_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i)
        && !($past(wb_adr_i) inside {8'h3c, 8'h40, 8'h54, 8'h58})
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    // ==========================================
    // Status bits mirror the selection outputs; interface flag holds while seeking
    chk_ai_status: assert property (wb_ack_o && !$past(wb_we_i) &&
        $past(wb_adr_i) == 8'h54
        |-> wb_dat_o[3] == $past(active_interface_flag_o))
        else $error("interface status differs");
    chk_line_src: assert property (wb_ack_o && !$past(wb_we_i) &&
        $past(wb_adr_i) == 8'h58
        |-> wb_dat_o[7] == $past(selected_line_sync_source_o))
        else $error("line source status differs");
    chk_frame_src: assert property (wb_ack_o && !$past(wb_we_i) &&
        $past(wb_adr_i) == 8'h58
        |-> wb_dat_o[5] == $past(selected_frame_sync_source_o))
        else $error("frame source status differs");
    chk_seek_hold: assert property (soft_power_down_o &&
        $past(soft_power_down_o) |-> $stable(active_interface_flag_o))
        else $error("interface flag moved in seek");
endmodule
bind sas_status sas_status_checker #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .active_interface_flag_o(active_interface_flag_o),
    .selected_line_sync_source_o(selected_line_sync_source_o),
    .selected_frame_sync_source_o(selected_frame_sync_source_o),
    .soft_power_down_o(soft_power_down_o));

// File: tb/sas_status_tb.sv
/* Self-checking bench for sas_status: Wishbone reads checked from a
   queue, sync lines from sas_sync_src. Assumes a 64-cycle window. */
`timescale 1ns/1ns
module sas_status_tb;
    localparam int WIN = 64;
    logic clk_i = 0;
    logic rst_i = 1;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o;
    logic wb_ack_o, ai, lsrc, fsrc, spd;
    logic [5:0] en = 0, pol = 0, idle = 0, pin;
    logic [31:0] exp_q[$], msk_q[$];
    int error_cnt = 0, n_tests = 0;
    always #50 clk_i = ~clk_i;
    sas_sync_src src (.clk_i(clk_i), .en_i(en), .pol_i(pol), .idle_i(idle),
        .sync_o(pin));
    sas_status #(.WINDOW_CYCLES(WIN)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_sync_i(pin[0]),
        .green_embedded_sync_i(pin[1]), .frame_sync_i(pin[2]),
        .dclk_i(pin[3]), .sep_frame_sync_i(pin[4]), .coast_i(pin[5]),
        .active_interface_flag_o(ai), .selected_line_sync_source_o(lsrc),
        .selected_frame_sync_source_o(fsrc), .soft_power_down_o(spd));
    task stop_test;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
        n_tests++;
        if (seen !== e)
        begin
            error_cnt++;
            $display("unexpected %s exp %h seen %h", nm, e, seen);
        end
    endtask
    task bus(input logic [7:0] a, input logic we, input logic [7:0] d,
        input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h0, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({24'h0, e & m});
        msk_q.push_back({24'hffffff, m});
        bus(a, 0, 8'h0, 4'hf);
    endtask
    // ==========================================
    // Read monitor: oldest note against each read answer
    always @(posedge clk_i)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
            check("rdata", wb_dat_o & msk_q.pop_front(),
                exp_q.pop_front());
    initial
    begin
        #2000000;
        error_cnt++;
        stop_test;
    end
    initial
    begin
        logic [7:0] c0f, c10;
        logic a, d, l, g, f, sk, ls, fs, x;
        void'($urandom(32'h3595b98e));
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        rd(8'h3c, 8'h0, 8'hff);
        rd(8'h40, 8'h0, 8'hff);
        rd(8'h54, 8'h0, 8'hff);
        rd(8'h58, 8'h10, 8'hff);
        rd(8'h00, 8'h0, 8'hff);
        rd(8'h55, 8'h0, 8'hff);
        bus(8'h3c, 1, 8'h06, 4'h0);
        rd(8'h3c, 8'h0, 8'h06);
        for (int i = 0; i < 16; i++)
        begin
            c0f = 8'($urandom) & 8'h06;
            c10 = 8'($urandom) & 8'h1b;
            en <= {2'b11, i[3:0]};
            pol <= 6'($urandom);
            idle <= 6'($urandom);
            bus(8'h3c, 1, c0f, 4'h1);
            bus(8'h40, 1, c10, 4'h1);
            bus(8'h54, 1, 8'hff, 4'h1);
            repeat (5 * WIN) @(posedge clk_i);
            {d, f, g, l} = i[3:0];
            a = l | g | f;
            sk = !a && !d && !c0f[2];
            ls = (c10[4] || l == g) ? c10[3] : g;
            fs = c10[1] ? c10[0] : f;
            x = (c0f[2] || (a && d)) ? c0f[1] : d;
            rd(8'h3c, c0f, 8'h06);
            rd(8'h40, c10, 8'h1b);
            rd(8'h54, {l, g, f, d, x, 3'h0},
                {4'hf, !sk, 3'h7});
            rd(8'h58, {ls, pol[0], fs, fs ? !pol[4] : !pol[2], pol[5], 3'h0},
                {1'b1, l, 1'b1, fs | f, 4'hf});
            check("seek", {31'h0, spd}, {31'h0, sk});
            check("iface", {31'h0, ai & !sk}, {31'h0, x & !sk});
            check("lsrc", {31'h0, lsrc}, {31'h0, ls});
            check("fsrc", {31'h0, fsrc}, {31'h0, fs});
        end
        // Mid-run reset with every line idling high: no false edges
        en <= 6'h00;
        idle <= 6'h3f;
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        repeat (3 * WIN) @(posedge clk_i);
        rd(8'h54, 8'h0, 8'hff);
        check("seek", {31'h0, spd}, 32'h1);
        stop_test;
    end
endmodule

// File: tb/sas_sync_src.sv
/* Video source model: line, green, frame, digital clock, separator
   and coast lines. Assumes the bench picks enables, polarities and
   idle levels; a disabled line holds its idle level. */
`timescale 1ns/1ns
module sas_sync_src (
    input wire logic clk_i,
    input wire logic [5:0] en_i,
    input wire logic [5:0] pol_i,
    input wire logic [5:0] idle_i,
    output logic [5:0] sync_o
);
    localparam int PER [6] = '{16, 12, 40, 4, 48, 32};
    localparam int WID [6] = '{3, 2, 4, 2, 5, 6};
    int cnt_q = 0;
    always @(posedge clk_i)
        cnt_q <= cnt_q + 1;
    // Short pulse at the active level (digital clock is a square wave), all periods inside one window
    always_comb
        for (int i = 0; i < 6; i++)
            sync_o[i] = en_i[i] ? ((cnt_q % PER[i] < WID[i]) ~^ pol_i[i])
                : idle_i[i];
endmodule
